// [logic/mca_pkg.sv]
// Package of encodings, flag layout and timing counts for the microcore misc ALU unit.
`default_nettype none
package mca_pkg;

  // Core clock and operation lengths.
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned MULI_CYCLES    = 17;
  localparam int unsigned SPI_RD_CYCLES  = 2;
  localparam logic [4:0]  MULI_CNT       = 5'(MULI_CYCLES - 1);
  localparam logic [1:0]  SPI_RD_CNT     = 2'(SPI_RD_CYCLES - 1);

  // Register map of the SPI-visible registers that this unit acts on.
  localparam logic [9:0] ADDR_CORE0_CONTROL_A  = 10'h101;
  localparam logic [9:0] ADDR_CORE0_CONTROL_B  = 10'h102;
  localparam logic [9:0] ADDR_CORE0_START_CFG  = 10'h104;
  localparam logic [9:0] ADDR_CORE0_STATUS_A   = 10'h105;
  localparam logic [9:0] ADDR_CORE0_STATUS_B   = 10'h106;
  localparam logic [9:0] ADDR_CORE0_IRQ_RETURN = 10'h10f;
  localparam logic [9:0] ADDR_CORE1_CONTROL_A  = 10'h121;
  localparam logic [9:0] ADDR_CORE1_CONTROL_B  = 10'h122;
  localparam logic [9:0] ADDR_CORE1_START_CFG  = 10'h124;
  localparam logic [9:0] ADDR_CORE1_STATUS_A   = 10'h125;
  localparam logic [9:0] ADDR_CORE1_STATUS_B   = 10'h126;
  localparam logic [9:0] ADDR_CORE1_IRQ_RETURN = 10'h12f;
  localparam logic [9:0] ADDR_DIAG_ERROR_FIRST = 10'h162;
  localparam logic [9:0] ADDR_DIAG_ERROR_LAST  = 10'h169;
  localparam int unsigned IRQ_RETURN_LSB       = 0;
  localparam int unsigned IRQ_RETURN_WIDTH     = 10;

  // Opcode patterns, matched on the fixed bits of each format.
  localparam logic [8:0]  OPC_MULI_HI     = 9'h04e;   // bits 15..7
  localparam logic [12:0] OPC_NOT_HI      = 13'h05db; // bits 15..3
  localparam logic [12:0] OPC_OR_HI       = 13'h05d8; // bits 15..3
  localparam logic [15:0] OPC_SPI_READ    = 16'h3540;
  localparam logic [13:0] OPC_SWI_HI      = 14'h0d62; // bits 15..2
  localparam logic [15:0] OPC_RET_SUB     = 16'h359c;
  localparam logic [12:0] OPC_RSTREG_HI   = 13'h06a9; // bits 15..3
  localparam logic [15:0] OPC_RST_LATCH   = 16'h359d;
  localparam logic [9:0]  OPC_PSHL_HI     = 10'h0e5;  // bits 15..6
  localparam logic [8:0]  OPC_PSHLC_HI    = 9'h071;   // bits 15..7
  localparam logic [2:0]  OPC_PSH_LO      = 3'h5;     // bits 2..0

  localparam logic [15:0] MASK_ZERO       = 16'h0000;
  localparam logic [15:0] MASK_ALL_ONES   = 16'hffff;

  // Clear target codes.
  localparam logic [2:0] TGT_SR           = 3'h0;
  localparam logic [2:0] TGT_CR           = 3'h1;
  localparam logic [2:0] TGT_SR_DIAG_HALT = 3'h2;
  localparam logic [2:0] TGT_ALL          = 3'h3;
  localparam logic [2:0] TGT_DIAG_HALT    = 3'h4;
  localparam logic [2:0] TGT_SR_CR        = 3'h5;
  localparam logic [2:0] TGT_SR_HALT      = 3'h6;
  localparam logic [2:0] TGT_HALT         = 3'h7;

  typedef enum logic [1:0] {
    MCA_ARITH_MUL   = 2'h0,
    MCA_ARITH_SHIFT = 2'h1
  } mca_arith_kind_t;

  typedef struct packed {
    logic overflow_flag;
    logic precision_loss_flag;
    logic operation_done_flag;
    logic mask_zero_flag;
    logic mask_all_ones_flag;
    logic shifted_out_bit_flag;
  } mca_flags_t;

  typedef struct packed {
    logic status_bits;
    logic control;
    logic diag_error;
    logic diag_rearm;
    logic start_latch;
  } mca_clear_t;

endpackage : mca_pkg
`default_nettype wire

// [logic/mca_product_unit.sv]
// Multi-cycle unit for the product pair: immediate multiply and left shifts.
`timescale 1ns/1ns
`default_nettype none
module mca_product_unit (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     start,
  input  wire mca_pkg::mca_arith_kind_t kind,
  input  wire logic [15:0]              first_operand,
  input  wire logic [15:0]              amount,
  output logic [31:0]                   product_pair_r,
  output logic                          busy_r,
  output logic                          done_r,
  output logic                          overflow_r,
  output logic                          precision_loss_r,
  output logic                          shifted_out_r
);

  logic [31:0]     product_pair_nxt;
  logic            busy_nxt;
  logic            done_nxt;
  logic            overflow_nxt;
  logic            precision_loss_nxt;
  logic            shifted_out_nxt;
  logic [15:0]     count_r;
  logic [15:0]     count_nxt;
  logic            is_mul_r;
  logic            is_mul_nxt;
  logic [31:0]     mul_result_r;
  logic [31:0]     mul_result_nxt;

  always_comb begin
    product_pair_nxt   = product_pair_r;
    busy_nxt           = busy_r;
    done_nxt           = 1'b0;
    overflow_nxt       = overflow_r;
    precision_loss_nxt = precision_loss_r;
    shifted_out_nxt    = shifted_out_r;
    count_nxt          = count_r;
    is_mul_nxt         = is_mul_r;
    mul_result_nxt     = mul_result_r;
    if (start && !busy_r) begin
      is_mul_nxt = (kind == mca_pkg::MCA_ARITH_MUL);
      if (kind == mca_pkg::MCA_ARITH_MUL) begin
        // Formed at once; counted one short because the core's state register adds a cycle.
        mul_result_nxt     = {16'h0000, first_operand} * {28'h0000000, amount[3:0]};
        count_nxt          = {11'h000, mca_pkg::MULI_CNT} - 16'h0001;
        busy_nxt           = 1'b1;
      end else begin
        // The first bit leaves at issue, so a shift by N of 1 or more holds the core N cycles; a shift by 0 holds it one cycle.
        done_nxt         = (amount < 16'h0002);
        busy_nxt         = !done_nxt;
        count_nxt        = amount - 16'h0002;
        shifted_out_nxt  = (amount != 16'h0000) && product_pair_r[31];
        overflow_nxt     = shifted_out_nxt;
        product_pair_nxt = (amount != 16'h0000) ? {product_pair_r[30:0], 1'b0} : product_pair_r;
      end
    end else if (busy_r) begin
      if (!is_mul_r) begin
        // One bit per core cycle; any one that leaves the top is an overflow.
        shifted_out_nxt  = product_pair_r[31];
        overflow_nxt     = overflow_r | product_pair_r[31];
        product_pair_nxt = {product_pair_r[30:0], 1'b0};
      end
      if (count_r == 16'h0000) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        if (is_mul_r) begin
          product_pair_nxt   = mul_result_r;
          overflow_nxt       = (mul_result_r[31:16] != 16'h0000);
          precision_loss_nxt = 1'b0;
        end
      end else begin
        count_nxt = count_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      product_pair_r   <= 32'h00000000;
      busy_r           <= 1'b0;
      done_r           <= 1'b0;
      overflow_r       <= 1'b0;
      precision_loss_r <= 1'b0;
      shifted_out_r    <= 1'b0;
      count_r          <= 16'h0000;
      is_mul_r         <= 1'b0;
      mul_result_r     <= 32'h00000000;
    end else begin
      product_pair_r   <= product_pair_nxt;
      busy_r           <= busy_nxt;
      done_r           <= done_nxt;
      overflow_r       <= overflow_nxt;
      precision_loss_r <= precision_loss_nxt;
      shifted_out_r    <= shifted_out_nxt;
      count_r          <= count_nxt;
      is_mul_r         <= is_mul_nxt;
      mul_result_r     <= mul_result_nxt;
    end
  end

endmodule : mca_product_unit
`default_nettype wire

// [logic/mca_misc_alu.sv]
// Execution unit of one microcore for the misc ALU, interrupt and register-clear instructions.
//
// Overview of operation
// - Immediate multiply puts register times 4-bit immediate into high and low product halves.
// - Immediate multiply lasts 17 cycles and updates overflow, precision-loss and done flags.
// - Invert complements the register, writes it back, flags all-zero and all-ones results.
// - OR merges the immediate holder into the register and updates the same mask flags.
// - SPI read request starts a backdoor read of the held address, done in 2 cycles.
// - Changing the SPI address in the next instruction aborts the read; data is meaningless.
// - Software interrupt stores the executing code address plus one in the 10-bit return field.
// - Ordinary interrupt returns to the interrupted line; software interrupt to that plus one.
// - Return from subroutine loads the program counter from the auxiliary return register.
// - Register clear acts on control, status and automatic diagnosis error registers.
// - Codes 000 status, 001 control, 010 status+diag+rearm, 011 status+control+diag+rearm.
// - Codes 100 diag+rearm, 101 status+control, 110 status+rearm, 111 rearm only.
// - Start-latch clear acts only while the core's smart latch enable bit is set.
// - Register product shift moves the pair left by register amount, that many cycles, one cycle for a zero amount.
// - Immediate product shift moves the pair left by a 4-bit amount, that many cycles, one cycle for a zero amount.
`timescale 1ns/1ns
`default_nettype none
module mca_misc_alu (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr,
  input  wire logic [9:0]          instr_addr,
  input  wire logic [15:0]         first_operand,
  input  wire logic [15:0]         constant_operand_holder,
  input  wire logic [9:0]          aux_return,
  input  wire logic                hw_irq_take,
  input  wire logic                smart_latch_enable,
  input  wire logic                spi_addr_write,
  output logic                     hold_fetch_r,
  output logic                     wb_valid_r,
  output logic [2:0]               wb_sel_r,
  output logic [15:0]              wb_data_r,
  output logic                     upc_load_r,
  output logic [9:0]               micro_program_counter_r,
  output logic [15:0]              product_high_half_r,
  output logic [15:0]              product_low_half_r,
  output mca_pkg::mca_flags_t      flags_r,
  output logic [9:0]               irq_return_r,
  output logic                     swi_req_r,
  output logic [1:0]               swi_id_r,
  output logic                     spi_rd_req_r,
  output logic                     spi_rd_done_r,
  output logic                     spi_rd_abort_r,
  output mca_pkg::mca_clear_t      clear_r
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode.

  typedef enum logic [2:0] {
    MCA_ST_IDLE  = 3'b001,
    MCA_ST_ARITH = 3'b010,
    MCA_ST_SPI   = 3'b100
  } mca_state_t;

  mca_state_t state_r;
  mca_state_t state_nxt;

  logic accept;
  logic dec_muli;
  logic dec_not;
  logic dec_or;
  logic dec_spi_rd;
  logic dec_swi;
  logic dec_ret;
  logic dec_rstreg;
  logic dec_rstsl;
  logic dec_pshl;
  logic dec_pshlc;

  // New instructions are only taken while nothing multi-cycle is running.
  assign accept     = instr_valid && (state_r == MCA_ST_IDLE);
  assign dec_muli   = accept && (instr[15:7] == mca_pkg::OPC_MULI_HI);
  assign dec_not    = accept && (instr[15:3] == mca_pkg::OPC_NOT_HI);
  assign dec_or     = accept && (instr[15:3] == mca_pkg::OPC_OR_HI);
  assign dec_spi_rd = accept && (instr == mca_pkg::OPC_SPI_READ);
  assign dec_swi    = accept && (instr[15:2] == mca_pkg::OPC_SWI_HI);
  assign dec_ret    = accept && (instr == mca_pkg::OPC_RET_SUB);
  assign dec_rstreg = accept && (instr[15:3] == mca_pkg::OPC_RSTREG_HI);
  assign dec_rstsl  = accept && (instr == mca_pkg::OPC_RST_LATCH);
  assign dec_pshl   = accept && (instr[15:6] == mca_pkg::OPC_PSHL_HI)
                      && (instr[2:0] == mca_pkg::OPC_PSH_LO);
  assign dec_pshlc  = accept && (instr[15:7] == mca_pkg::OPC_PSHLC_HI)
                      && (instr[2:0] == mca_pkg::OPC_PSH_LO);

  //////////////////////////////////////////////////////////////////////////////
  // Product pair unit.

  logic                     pu_start;
  mca_pkg::mca_arith_kind_t pu_kind;
  logic [15:0]              pu_amount;
  logic [31:0]              product_pair;
  logic                     pu_done;
  logic                     pu_overflow;
  logic                     pu_precision_loss;
  logic                     pu_shifted_out;

  assign pu_start  = dec_muli || dec_pshl || dec_pshlc;
  assign pu_kind   = dec_muli ? mca_pkg::MCA_ARITH_MUL : mca_pkg::MCA_ARITH_SHIFT;
  // Register shift takes the whole register value; both immediates are 4 bits.
  assign pu_amount = dec_pshl ? first_operand : {12'h000, instr[6:3]};

  mca_product_unit u_product (
    .clk              (clk),
    .rstn             (rstn),
    .start            (pu_start),
    .kind             (pu_kind),
    .first_operand    (first_operand),
    .amount           (pu_amount),
    .product_pair_r   (product_pair),
    .busy_r           (),
    .done_r           (pu_done),
    .overflow_r       (pu_overflow),
    .precision_loss_r (pu_precision_loss),
    .shifted_out_r    (pu_shifted_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing state.

  logic [1:0] spi_cnt_r;
  logic [1:0] spi_cnt_nxt;
  logic       spi_watch_r;
  logic       spi_watch_nxt;
  logic       hold_fetch_nxt;
  logic       is_mul_op_r;
  logic       is_mul_op_nxt;

  always_comb begin
    state_nxt      = state_r;
    spi_cnt_nxt    = spi_cnt_r;
    spi_watch_nxt  = spi_watch_r;
    is_mul_op_nxt  = is_mul_op_r;
    case (state_r)
      MCA_ST_IDLE: begin
        if (pu_start) begin
          state_nxt     = MCA_ST_ARITH;
          is_mul_op_nxt = dec_muli;
        end else if (dec_spi_rd) begin
          state_nxt     = MCA_ST_SPI;
          spi_cnt_nxt   = mca_pkg::SPI_RD_CNT;
          spi_watch_nxt = 1'b1;
        end
      end
      MCA_ST_ARITH: begin
        if (pu_done) begin
          state_nxt = MCA_ST_IDLE;
        end
      end
      MCA_ST_SPI: begin
        if (spi_cnt_r == 2'h0) begin
          state_nxt = MCA_ST_IDLE;
        end else begin
          spi_cnt_nxt = spi_cnt_r - 2'h1;
        end
      end
      default: begin
        state_nxt = MCA_ST_IDLE;
      end
    endcase
    // The address guard lasts until the instruction after the read has been taken.
    if (spi_watch_r && accept) begin
      spi_watch_nxt = 1'b0;
    end
    hold_fetch_nxt = (state_nxt != MCA_ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= MCA_ST_IDLE;
      spi_cnt_r    <= 2'h0;
      spi_watch_r  <= 1'b0;
      hold_fetch_r <= 1'b0;
      is_mul_op_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      spi_cnt_r    <= spi_cnt_nxt;
      spi_watch_r  <= spi_watch_nxt;
      hold_fetch_r <= hold_fetch_nxt;
      is_mul_op_r  <= is_mul_op_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Results, flags and strobes.

  logic                wb_valid_nxt;
  logic [2:0]          wb_sel_nxt;
  logic [15:0]         wb_data_nxt;
  logic                upc_load_nxt;
  logic [9:0]          upc_nxt;
  mca_pkg::mca_flags_t flags_nxt;
  logic [9:0]          irq_return_nxt;
  logic                swi_req_nxt;
  logic [1:0]          swi_id_nxt;
  logic                spi_rd_req_nxt;
  logic                spi_rd_done_nxt;
  logic                spi_rd_abort_nxt;
  mca_pkg::mca_clear_t clear_nxt;
  logic [15:0]         mask_result;

  always_comb begin
    wb_valid_nxt     = 1'b0;
    wb_sel_nxt       = wb_sel_r;
    wb_data_nxt      = wb_data_r;
    upc_load_nxt     = 1'b0;
    upc_nxt          = micro_program_counter_r;
    flags_nxt        = flags_r;
    irq_return_nxt   = irq_return_r;
    swi_req_nxt      = 1'b0;
    swi_id_nxt       = swi_id_r;
    spi_rd_req_nxt   = 1'b0;
    spi_rd_done_nxt  = 1'b0;
    spi_rd_abort_nxt = 1'b0;
    clear_nxt        = '0;
    mask_result      = dec_not ? ~first_operand
                               : (first_operand | constant_operand_holder);

    if (dec_not || dec_or) begin
      wb_valid_nxt                 = 1'b1;
      wb_sel_nxt                   = instr[2:0];
      wb_data_nxt                  = mask_result;
      flags_nxt.mask_zero_flag     = (mask_result == mca_pkg::MASK_ZERO);
      flags_nxt.mask_all_ones_flag = (mask_result == mca_pkg::MASK_ALL_ONES);
    end

    if (dec_muli) begin
      // Done drops at issue so the program sees it rise only at completion.
      flags_nxt.operation_done_flag = 1'b0;
    end
    if (pu_done) begin
      flags_nxt.overflow_flag = pu_overflow;
      if (is_mul_op_r) begin
        flags_nxt.precision_loss_flag = pu_precision_loss;
        flags_nxt.operation_done_flag = 1'b1;
      end else begin
        flags_nxt.shifted_out_bit_flag = pu_shifted_out;
      end
    end

    if (dec_swi) begin
      // Resuming at the next line keeps the request from being replayed.
      irq_return_nxt = instr_addr + 10'h001;
      swi_req_nxt    = 1'b1;
      swi_id_nxt     = instr[1:0];
    end else if (hw_irq_take) begin
      irq_return_nxt = instr_addr;
    end

    if (dec_ret) begin
      upc_load_nxt = 1'b1;
      upc_nxt      = aux_return;
    end

    if (dec_spi_rd) begin
      spi_rd_req_nxt = 1'b1;
    end
    if ((state_r == MCA_ST_SPI) && (spi_cnt_r == 2'h0)) begin
      spi_rd_done_nxt = 1'b1;
    end
    // Only the instruction right after the read is policed; later changes are legal.
    if (spi_watch_r && accept && spi_addr_write) begin
      spi_rd_abort_nxt = 1'b1;
    end

    if (dec_rstreg) begin
      case (instr[2:0])
        mca_pkg::TGT_SR: begin
          clear_nxt.status_bits = 1'b1;
        end
        mca_pkg::TGT_CR: begin
          clear_nxt.control = 1'b1;
        end
        mca_pkg::TGT_SR_DIAG_HALT: begin
          clear_nxt.status_bits = 1'b1;
          clear_nxt.diag_error  = 1'b1;
          clear_nxt.diag_rearm  = 1'b1;
        end
        mca_pkg::TGT_ALL: begin
          clear_nxt.status_bits = 1'b1;
          clear_nxt.control     = 1'b1;
          clear_nxt.diag_error  = 1'b1;
          clear_nxt.diag_rearm  = 1'b1;
        end
        mca_pkg::TGT_DIAG_HALT: begin
          clear_nxt.diag_error = 1'b1;
          clear_nxt.diag_rearm = 1'b1;
        end
        mca_pkg::TGT_SR_CR: begin
          clear_nxt.status_bits = 1'b1;
          clear_nxt.control     = 1'b1;
        end
        mca_pkg::TGT_SR_HALT: begin
          clear_nxt.status_bits = 1'b1;
          clear_nxt.diag_rearm  = 1'b1;
        end
        default: begin
          clear_nxt.diag_rearm = 1'b1;
        end
      endcase
    end

    if (dec_rstsl && smart_latch_enable) begin
      clear_nxt.start_latch = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_valid_r              <= 1'b0;
      wb_sel_r                <= 3'h0;
      wb_data_r               <= 16'h0000;
      upc_load_r              <= 1'b0;
      micro_program_counter_r <= 10'h000;
      flags_r                 <= '0;
      irq_return_r            <= 10'h000;
      swi_req_r               <= 1'b0;
      swi_id_r                <= 2'h0;
      spi_rd_req_r            <= 1'b0;
      spi_rd_done_r           <= 1'b0;
      spi_rd_abort_r          <= 1'b0;
      clear_r                 <= '0;
    end else begin
      wb_valid_r              <= wb_valid_nxt;
      wb_sel_r                <= wb_sel_nxt;
      wb_data_r               <= wb_data_nxt;
      upc_load_r              <= upc_load_nxt;
      micro_program_counter_r <= upc_nxt;
      flags_r                 <= flags_nxt;
      irq_return_r            <= irq_return_nxt;
      swi_req_r               <= swi_req_nxt;
      swi_id_r                <= swi_id_nxt;
      spi_rd_req_r            <= spi_rd_req_nxt;
      spi_rd_done_r           <= spi_rd_done_nxt;
      spi_rd_abort_r          <= spi_rd_abort_nxt;
      clear_r                 <= clear_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Product halves are re-registered so the ports come from local flip-flops.

  logic [15:0] product_high_nxt;
  logic [15:0] product_low_nxt;

  always_comb begin
    product_high_nxt = product_pair[31:16];
    product_low_nxt  = product_pair[15:0];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      product_high_half_r <= 16'h0000;
      product_low_half_r  <= 16'h0000;
    end else begin
      product_high_half_r <= product_high_nxt;
      product_low_half_r  <= product_low_nxt;
    end
  end

endmodule : mca_misc_alu
`default_nettype wire

// [bench/mca_code_ram.sv]
// Code RAM model that holds the microcode words fetched by the core.
`timescale 1ns/1ns
`default_nettype none
module mca_code_ram (
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [9:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [9:0]  raddr,
  output logic [15:0]      rdata
);
  logic [15:0] mem [1024];
  always_ff @(posedge clk) if (we) mem[waddr] <= wdata;
  // Reads are combinational so a word written at one edge is fetchable at the next.
  assign rdata = mem[raddr];
endmodule : mca_code_ram
`default_nettype wire

// [bench/mca_misc_alu_assertions.sv]
// Port checker for the misc ALU unit.
`timescale 1ns/1ns
`default_nettype none
module mca_misc_alu_chk (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                instr_valid,
  input wire logic [15:0]         instr,
  input wire logic [9:0]          instr_addr,
  input wire logic [15:0]         first_operand,
  input wire logic [9:0]          aux_return,
  input wire logic                hw_irq_take,
  input wire logic                smart_latch_enable,
  input wire logic                hold_fetch_r,
  input wire logic                wb_valid_r,
  input wire logic [15:0]         wb_data_r,
  input wire logic                upc_load_r,
  input wire logic [9:0]          micro_program_counter_r,
  input wire mca_pkg::mca_flags_t flags_r,
  input wire logic [9:0]          irq_return_r,
  input wire logic                swi_req_r,
  input wire logic                spi_rd_req_r,
  input wire logic                spi_rd_done_r,
  input wire mca_pkg::mca_clear_t clear_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // The cycle just after a multi-cycle issue is not counted here, so no driver may use it.
  wire tk = instr_valid && !hold_fetch_r;
  property p_not; tk && instr[15:3] == mca_pkg::OPC_NOT_HI
    |=> wb_valid_r && wb_data_r == ~$past(first_operand); endproperty
  a_not: assert property (p_not) else $error("invert result wrong");
  property p_mask; wb_valid_r |-> flags_r.mask_zero_flag == (wb_data_r == 16'h0000)
    && flags_r.mask_all_ones_flag == (wb_data_r == 16'hffff); endproperty
  a_mask: assert property (p_mask) else $error("mask flags wrong");
  property p_spi; tk && instr == mca_pkg::OPC_SPI_READ
    |=> spi_rd_req_r && hold_fetch_r ##2 spi_rd_done_r && !hold_fetch_r; endproperty
  a_spi: assert property (p_spi) else $error("spi read timing wrong");
  property p_swi; tk && instr[15:2] == mca_pkg::OPC_SWI_HI
    |=> swi_req_r && irq_return_r == $past(instr_addr) + 10'h001; endproperty
  a_swi: assert property (p_swi) else $error("swi return wrong");
  property p_hwi; hw_irq_take |=> irq_return_r == $past(instr_addr); endproperty
  a_hwi: assert property (p_hwi) else $error("irq return wrong");
  property p_rfs; tk && instr == mca_pkg::OPC_RET_SUB
    |=> upc_load_r && micro_program_counter_r == $past(aux_return); endproperty
  a_rfs: assert property (p_rfs) else $error("return load wrong");
  property p_latch; tk && instr == mca_pkg::OPC_RST_LATCH
    |=> clear_r.start_latch == $past(smart_latch_enable); endproperty
  a_latch: assert property (p_latch) else $error("latch clear wrong");
  property p_muli; tk && instr[15:7] == mca_pkg::OPC_MULI_HI |=> hold_fetch_r[*8]
    ##10 !hold_fetch_r && flags_r.operation_done_flag; endproperty
  a_muli: assert property (p_muli) else $error("multiply length wrong");
endmodule : mca_misc_alu_chk
bind mca_misc_alu mca_misc_alu_chk i_mca_misc_alu_chk (.*);
`default_nettype wire

// [bench/tb_mca_misc_alu.sv]
// Self-checking bench for the misc ALU unit.
`timescale 1ns/1ns
`default_nettype none
module tb_mca_misc_alu;
  logic clk, rstn, vld, hw, sle, spw, we, hold, wbv, upl, swr, srq, sdn, sab;
  logic [15:0] fop, cho, wd, ins, wdat, ph, pl;
  logic [9:0] ia, aux, wa, pc, irr;
  logic [2:0] wsel;
  logic [1:0] sid;
  mca_pkg::mca_flags_t fl;
  mca_pkg::mca_clear_t cl;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  logic [15:0] rows [6][4] = '{'{16'h2eda, 16'hffff, 16'h0000, 16'h0000},
    '{16'h2edd, 16'h0000, 16'h0000, 16'hffff}, '{16'h2ed8, 16'h5a3c, 16'h0000, 16'ha5c3},
    '{16'h2ec3, 16'h00f0, 16'h0f0f, 16'h0fff}, '{16'h2ec1, 16'hff00, 16'h00ff, 16'hffff},
    '{16'h2ec7, 16'h0000, 16'h0000, 16'h0000}};
  logic [4:0] clr_exp [8] = '{5'h10, 5'h08, 5'h16, 5'h1e, 5'h06, 5'h18, 5'h12, 5'h02};
  mca_code_ram i_mca_code_ram (.clk(clk), .we(we), .waddr(wa), .wdata(wd), .raddr(ia),
    .rdata(ins));
  mca_misc_alu i_mca_misc_alu (.clk(clk), .rstn(rstn), .instr_valid(vld), .instr(ins),
    .instr_addr(ia), .first_operand(fop), .constant_operand_holder(cho), .aux_return(aux),
    .hw_irq_take(hw), .smart_latch_enable(sle), .spi_addr_write(spw), .hold_fetch_r(hold),
    .wb_valid_r(wbv), .wb_sel_r(wsel), .wb_data_r(wdat), .upc_load_r(upl),
    .micro_program_counter_r(pc), .product_high_half_r(ph), .product_low_half_r(pl),
    .flags_r(fl), .irq_return_r(irr), .swi_req_r(swr), .swi_id_r(sid), .spi_rd_req_r(srq),
    .spi_rd_done_r(sdn), .spi_rd_abort_r(sab), .clear_r(cl));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  // Stores the word in code RAM, then presents it for exactly one taken edge.
  task automatic issue(input logic [9:0] a, input logic [15:0] w);
    step();
    {we, wa, wd} = {1'b1, a, w};
    step();
    {we, ia, vld} = {1'b0, a, 1'b1};
    step();
    vld = 0;
  endtask : issue
  task automatic run(input logic [15:0] w, input int waits);
    issue(10'h040, w);
    n = 0;
    while (hold === 1'b1 && n < 40) begin
      step();
      n++;
    end
    chk("cycles", n, waits);
    step();
  endtask : run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rstn, vld, hw, sle, spw, we, fop, cho, wd, ia, aux, wa} = '0;
    repeat (16) @(posedge clk);
    #1 rstn = 1;
    chk("reset", {hold, fl, cl, wbv, swr, upl}, 0);
    foreach (rows[i]) begin
      {fop, cho} = {rows[i][1], rows[i][2]};
      issue(10'h010, rows[i][0]);
      chk("wb", {wbv, wsel, wdat}, {1'b1, rows[i][0][2:0], rows[i][3]});
      chk("masks", {fl.mask_zero_flag, fl.mask_all_ones_flag},
        {rows[i][3] == 16'h0000, rows[i][3] == 16'hffff});
    end
    for (int c = 0; c < 8; c++) begin
      issue(10'h020, 16'h3548 | 16'(c));
      chk("clear", cl, clr_exp[c]);
    end
    for (int s = 0; s < 2; s++) begin
      sle = s[0];
      issue(10'h030, mca_pkg::OPC_RST_LATCH);
      chk("latch", cl.start_latch, s[0]);
    end
    aux = 10'h155;
    // No ordinary interrupt is raised around the software request.
    issue(10'h2a5, 16'h358a);
    chk("swi", {swr, sid, irr}, {1'b1, 2'h2, 10'h2a6});
    issue(10'h050, mca_pkg::OPC_RET_SUB);
    chk("rfs", {upl, pc}, {1'b1, 10'h155});
    {ia, hw} = {10'h111, 1'b1};
    step();
    hw = 0;
    chk("hw_irq", irr, 10'h111);
    fop = 16'h1234;
    run(16'h2779, 17);
    chk("muli", {ph, pl}, 32'h0001110c);
    chk("muli_fl", {fl.overflow_flag, fl.precision_loss_flag, fl.operation_done_flag}, 3'h5);
    fop = 16'h0010;
    run(16'h3955, 16);
    chk("shl_reg", {ph, pl, fl.overflow_flag, fl.shifted_out_bit_flag}, {32'h110c0000, 2'h3});
    run(16'h389d, 3);
    chk("shl_imm", {ph, pl, fl.overflow_flag, fl.shifted_out_bit_flag}, {32'h88600000, 2'h0});
    issue(10'h060, mca_pkg::OPC_SPI_READ);
    chk("spi_req", {srq, hold}, 2'h3);
    step();
    step();
    chk("spi_done", {sdn, hold}, 2'h2);
    spw = 1;
    issue(10'h061, 16'h2ed8);
    spw = 0;
    chk("spi_abort", sab, 1'b1);
    report_and_stop();
  end
endmodule : tb_mca_misc_alu
`default_nettype wire
